// ### verilog/byte_alu_regs.vh
// Purpose: constants for the byte ALU datapath
// Assumes: included by bare name
// Notes: opcode encodings are local to this block
`ifndef BYTE_ALU_REGS_VH
`define BYTE_ALU_REGS_VH
// Operation select codes
`define OP_W 3
`define OP_NONE 3'h0
`define OP_SUB 3'h1
`define OP_SUBB 3'h2
`define OP_SWAP 3'h3
`define OP_XORL 3'h4
`define OP_XORF 3'h5
`define OP_LOAD_DIRECTION_REGISTER 3'h6
// Operand ranges
`define ADDR_W 7
`define DATA_W 8
`define LOAD_DIRECTION_REGISTER_SEL_A 7'h05
`define LOAD_DIRECTION_REGISTER_SEL_B 7'h06
`define LOAD_DIRECTION_REGISTER_SEL_C 7'h07
// Destination select
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1
// Reset values and bit positions
`define ACC_RST 8'h00
`define ADDR_RST 7'h00
`define DIR_RST 8'hFF
`define BYTE_ZERO 8'h00
`define NIB_MSB 3
`define BYTE_MSB 7
`endif

// ### verilog/byte_sub_unit.v
// Purpose: 8-bit subtract f - w - borrow with carry and nibble carry
// Assumes: carry is the inverted borrow
// Notes: purely combinational
`timescale 1ns/1ps
`include "byte_alu_regs.vh"
module byte_sub_unit
(
  // Operands
  input wire [7:0] f_val,
  input wire [7:0] w_val,
  input wire borrow_in,
  // Results
  output wire [7:0] diff,
  output wire carry_out,
  output wire nib_carry_out
);
  wire [8:0] full;
  wire [4:0] low;
  // Add inverted w plus carry-in: carry out means no borrow
  assign full = {1'b0, f_val} + {1'b0, ~w_val} + {8'h00, ~borrow_in};
  assign low = {1'b0, f_val[`NIB_MSB:0]} + {1'b0, ~w_val[`NIB_MSB:0]} + {4'h0, ~borrow_in};
  assign diff = full[`BYTE_MSB:0];
  assign carry_out = full[`DATA_W];
  assign nib_carry_out = low[`NIB_MSB + 1];
endmodule // byte_sub_unit

// ### verilog/byte_alu_sub_xor_swap.v
// Purpose: datapath for subtract, borrow-subtract, nibble swap, xor and direction load
// Assumes: decoder gives one-cycle op strobe with file data already read
// Notes: all outputs registered; file write is a one-cycle pulse
//        carry follows the adder, so borrow subtract sets it when f >= w + borrow
//        dest_sel is ignored for literal xor and direction load
//
// How it works
// RL1: Plain subtract gives file minus accumulator, carry and nibble carry set when no borrow, zero updated.
// RL2: Borrow subtract also takes off the inverted carry and updates carry, nibble carry and zero.
// RL3: Destination bit 0 sends the result to the accumulator, 1 writes it back to the 7-bit file address.
// RL4: Nibble swap exchanges the two nibbles of the file byte and leaves every flag alone.
// RL5: Literal xor combines accumulator with an 8-bit immediate into the accumulator, zero only.
// RL6: File xor combines accumulator with file byte into the chosen destination, zero only.
// RL7: Direction load copies the accumulator into port A, B or C direction for operands 5, 6, 7, flags kept.
// RL8: Zero flag is set exactly when the 8-bit result is zero wherever it is affected.
`timescale 1ns/1ps
`include "byte_alu_regs.vh"
module byte_alu_sub_xor_swap
(
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Operation request
  input wire op_valid,
  input wire [2:0] op_sel,
  input wire [6:0] file_addr,
  input wire dest_sel,
  input wire [7:0] file_rdata,
  input wire [7:0] literal,
  // File write-back
  output reg file_we_r,
  output reg [6:0] file_waddr_r,
  output reg [7:0] file_wdata_r,
  // Accumulator and status
  output reg [7:0] acc_r,
  output reg carry_flag_r,
  output reg nibble_carry_flag_r,
  output reg zero_flag_r,
  // Port direction registers
  output reg [7:0] port_a_direction_r,
  output reg [7:0] port_b_direction_r,
  output reg [7:0] port_c_direction_r
);

  // ********************************
  // Helpers
  // ********************************
  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == `BYTE_ZERO); // RL8
    end
  endfunction

  function dir_hit;
    input [6:0] operand;
    input [6:0] sel;
    begin
      dir_hit = (operand == sel); // RL7
    end
  endfunction

  // ********************************
  // Subtractor
  // ********************************
  wire [7:0] sub_diff;
  wire sub_c;
  wire sub_dc;
  wire use_borrow;
  // One adder serves both subtracts, so flags match the result bit for bit
  // Plain subtract forces no borrow in
  assign use_borrow = (op_sel == `OP_SUBB) ? ~carry_flag_r : 1'b0; // RL2

  byte_sub_unit u_sub
  (
    .f_val(file_rdata),
    .w_val(acc_r),
    .borrow_in(use_borrow),
    .diff(sub_diff),
    .carry_out(sub_c),
    .nib_carry_out(sub_dc)
  );

  // ********************************
  // Result select
  // ********************************
  reg [7:0] result;
  reg has_result;
  reg upd_cdc;
  reg upd_z;
  always @*
  begin
    result = `BYTE_ZERO;
    has_result = 1'b0;
    upd_cdc = 1'b0;
    upd_z = 1'b0;
    case (op_sel)
      `OP_SUB, `OP_SUBB:
      begin
        result = sub_diff; // RL1 RL2
        has_result = 1'b1;
        upd_cdc = 1'b1;
        upd_z = 1'b1;
      end
      `OP_SWAP:
      begin
        result = {file_rdata[`NIB_MSB:0], file_rdata[`BYTE_MSB:`NIB_MSB + 1]}; // RL4
        has_result = 1'b1;
      end
      `OP_XORL:
      begin
        result = acc_r ^ literal; // RL5
        upd_z = 1'b1;
      end
      `OP_XORF:
      begin
        result = acc_r ^ file_rdata; // RL6
        has_result = 1'b1;
        upd_z = 1'b1;
      end
      // Ops 0, 6 and 7 leave has_result low
      default:
      begin
        result = `BYTE_ZERO;
      end
    endcase
  end

  // ********************************
  // Next values
  // ********************************
  reg file_we_nxt;
  reg [6:0] file_waddr_nxt;
  reg [7:0] file_wdata_nxt;
  reg [7:0] acc_nxt;
  reg carry_flag_nxt;
  reg nibble_carry_flag_nxt;
  reg zero_flag_nxt;
  reg [7:0] port_a_direction_nxt;
  reg [7:0] port_b_direction_nxt;
  reg [7:0] port_c_direction_nxt;
  wire to_file;
  wire to_acc;

  // Literal xor never raises has_result, so dest_sel cannot send it to the file
  assign to_file = op_valid && has_result && (dest_sel == `DEST_FILE); // RL3
  assign to_acc = op_valid && !to_file && (has_result || (op_sel == `OP_XORL)); // RL3 RL5

  always @*
  begin
    // Hold by default; only the write strobe falls back to idle
    file_we_nxt = 1'b0;
    file_waddr_nxt = file_waddr_r;
    file_wdata_nxt = file_wdata_r;
    acc_nxt = acc_r;
    carry_flag_nxt = carry_flag_r;
    nibble_carry_flag_nxt = nibble_carry_flag_r;
    zero_flag_nxt = zero_flag_r;
    port_a_direction_nxt = port_a_direction_r;
    port_b_direction_nxt = port_b_direction_r;
    port_c_direction_nxt = port_c_direction_r;
    if (to_file)
    begin
      file_we_nxt = 1'b1; // RL3
      file_waddr_nxt = file_addr;
      file_wdata_nxt = result;
    end
    if (to_acc)
      acc_nxt = result; // RL3 RL5
    if (op_valid && upd_cdc)
    begin
      carry_flag_nxt = sub_c; // RL1 RL2
      nibble_carry_flag_nxt = sub_dc;
    end
    if (op_valid && upd_z)
      zero_flag_nxt = is_zero(result); // RL8
    // Operand outside 5..7 loads nothing, as a refused op
    if (op_valid && (op_sel == `OP_LOAD_DIRECTION_REGISTER))
    begin
      if (dir_hit(file_addr, `LOAD_DIRECTION_REGISTER_SEL_A))
        port_a_direction_nxt = acc_r; // RL7
      if (dir_hit(file_addr, `LOAD_DIRECTION_REGISTER_SEL_B))
        port_b_direction_nxt = acc_r; // RL7
      if (dir_hit(file_addr, `LOAD_DIRECTION_REGISTER_SEL_C))
        port_c_direction_nxt = acc_r; // RL7
    end
  end

  // ********************************
  // Registers
  // ********************************
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      // Direction registers come up as all input
      file_we_r <= 1'b0;
      file_waddr_r <= `ADDR_RST;
      file_wdata_r <= `BYTE_ZERO;
      acc_r <= `ACC_RST;
      carry_flag_r <= 1'b0;
      nibble_carry_flag_r <= 1'b0;
      zero_flag_r <= 1'b0;
      port_a_direction_r <= `DIR_RST;
      port_b_direction_r <= `DIR_RST;
      port_c_direction_r <= `DIR_RST;
    end
    else
    begin
      // Load next values every edge
      file_we_r <= file_we_nxt;
      file_waddr_r <= file_waddr_nxt;
      file_wdata_r <= file_wdata_nxt;
      acc_r <= acc_nxt;
      carry_flag_r <= carry_flag_nxt;
      nibble_carry_flag_r <= nibble_carry_flag_nxt;
      zero_flag_r <= zero_flag_nxt;
      port_a_direction_r <= port_a_direction_nxt;
      port_b_direction_r <= port_b_direction_nxt;
      port_c_direction_r <= port_c_direction_nxt;
    end
  end
endmodule // byte_alu_sub_xor_swap

// ### tb/file_model.sv
// Purpose: data file behind the datapath
// Assumes: read is combinational on address
// Notes: byte i starts holding i
`timescale 1ns/1ps
module file_model
(
  // File port
  input wire clock,
  input wire we,
  input wire [6:0] ra,
  input wire [6:0] wa,
  input wire [7:0] wd,
  output wire [7:0] rd
);
  reg [7:0] m [0:127];
  integer i;
  initial
    for (i = 0; i < 8'h80; i = i + 1)
      m[i] = i[7:0];
  assign rd = m[ra];
  always @(posedge clock)
    if (we)
      m[wa] <= wd;
endmodule // file_model

// ### tb/byte_alu_monitor.sv
// Purpose: port checker for the byte datapath
// Assumes: results land one edge after op_valid
// Notes: bound to the top module
`timescale 1ns/1ps
module byte_alu_monitor
(
  // Watched ports
  input wire clock,
  input wire nrst,
  input wire op_valid,
  input wire [2:0] op_sel,
  input wire [6:0] file_addr,
  input wire dest_sel,
  input wire [7:0] file_rdata,
  input wire [7:0] literal,
  input wire file_we_r,
  input wire [6:0] file_waddr_r,
  input wire [7:0] acc_r,
  input wire carry_flag_r,
  input wire nibble_carry_flag_r,
  input wire zero_flag_r,
  input wire [7:0] port_a_direction_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire [2:0] fl = {carry_flag_r, nibble_carry_flag_r, zero_flag_r};
  AST_SUB_RES: assert property (op_valid && op_sel == 3'h1 && !dest_sel |=>
    acc_r == $past(file_rdata - acc_r)) else $error("sub result wrong");
  AST_SUB_CARRY: assert property (op_valid && op_sel == 3'h1 |=>
    carry_flag_r == ($past(acc_r) <= $past(file_rdata))) else $error("sub carry wrong");
  AST_SUBB_RES: assert property (op_valid && op_sel == 3'h2 && !dest_sel |=>
    acc_r == $past(file_rdata - acc_r - !carry_flag_r)) else $error("borrow sub wrong");
  AST_DEST_FILE: assert property (op_valid && dest_sel && op_sel inside {1, 2, 3, 5} |=>
    file_we_r && file_waddr_r == $past(file_addr) && $stable(acc_r)) else $error("file write wrong");
  AST_SWAP_FLAGS: assert property (op_valid && op_sel == 3'h3 |=> $stable(fl)) else $error("swap moved flags");
  AST_XORL: assert property (op_valid && op_sel == 3'h4 |=>
    acc_r == ($past(acc_r) ^ $past(literal)) && !file_we_r && $stable(fl[2:1])) else $error("xor literal wrong");
  AST_XORF_ZERO: assert property (op_valid && op_sel == 3'h5 |=>
    zero_flag_r == (($past(acc_r) ^ $past(file_rdata)) == 8'h00)) else $error("xor zero wrong");
  AST_DIR_A: assert property (op_valid && op_sel == 3'h6 && file_addr == 7'h05 |=>
    port_a_direction_r == $past(acc_r) && $stable(fl)) else $error("direction load wrong");
  cover property (op_valid && op_sel == 3'h2);
  cover property (op_valid && op_sel == 3'h5 && dest_sel);
  cover property (op_valid && op_sel == 3'h6);
endmodule // byte_alu_monitor
bind byte_alu_sub_xor_swap byte_alu_monitor mon (.clock(clock), .nrst(nrst), .op_valid(op_valid),
  .op_sel(op_sel), .file_addr(file_addr), .dest_sel(dest_sel), .file_rdata(file_rdata), .literal(literal),
  .file_we_r(file_we_r), .file_waddr_r(file_waddr_r), .acc_r(acc_r), .carry_flag_r(carry_flag_r),
  .nibble_carry_flag_r(nibble_carry_flag_r), .zero_flag_r(zero_flag_r), .port_a_direction_r(port_a_direction_r));

// ### tb/byte_alu_sub_xor_swap_bench.sv
// Purpose: directed bench for the byte datapath
// Assumes: one idle cycle between ops
// Notes: expectations from a shadow model
`timescale 1ns/1ps
module byte_alu_sub_xor_swap_bench;
  reg clock = 0, nrst = 0, op_valid = 0, dest_sel = 0, c = 0, dc = 0, z = 0, b, we;
  reg [2:0] op_sel = 0;
  reg [6:0] file_addr = 0;
  reg [7:0] literal = 0, w = 0, r, f, fm [0:127], d [0:2];
  wire [7:0] file_rdata, file_wdata_r, acc_r, pa, pb, pc;
  wire [6:0] file_waddr_r;
  wire file_we_r, cf, nf, zf;
  integer fail_count = 0, checks_done = 0, i;
  always #2.5 clock = ~clock;
  byte_alu_sub_xor_swap uut (.clock(clock), .nrst(nrst), .op_valid(op_valid), .op_sel(op_sel),
    .file_addr(file_addr), .dest_sel(dest_sel), .file_rdata(file_rdata), .literal(literal),
    .file_we_r(file_we_r), .file_waddr_r(file_waddr_r), .file_wdata_r(file_wdata_r), .acc_r(acc_r),
    .carry_flag_r(cf), .nibble_carry_flag_r(nf), .zero_flag_r(zf),
    .port_a_direction_r(pa), .port_b_direction_r(pb), .port_c_direction_r(pc));
  file_model fmod (.clock(clock), .we(file_we_r), .ra(file_addr), .wa(file_waddr_r), .wd(file_wdata_r),
    .rd(file_rdata));
  task chk(input [8*5:1] n, input [7:0] e, input [7:0] g);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %0s exp %h got %h", n, e, g);
    end
  end
  endtask
  task chk_bit(input [8*5:1] n, input e, input g);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %0s exp %b got %b", n, e, g);
    end
  end
  endtask
  task op(input [2:0] s, input [6:0] a, input dd, input [7:0] k);
  begin
    f = fm[a];
    r = w;
    b = (s == 3'h2) & ~c;
    if (s == 3'h1 || s == 3'h2)
    begin
      r = f - w - b;
      c = {1'b0, f} >= w + b;
      dc = {1'b0, f[3:0]} >= w[3:0] + b;
    end
    if (s == 3'h3)
      r = {f[3:0], f[7:4]};
    if (s == 3'h4 || s == 3'h5)
      r = w ^ (s[0] ? f : k);
    if (s == 3'h1 || s == 3'h2 || s == 3'h4 || s == 3'h5)
      z = r == 8'h00;
    if (s == 3'h6 && a >= 7'h05 && a <= 7'h07)
      d[a - 7'h05] = w;
    we = dd && s != 3'h0 && s < 3'h6 && s != 3'h4;
    if (we)
      fm[a] = r;
    else
      w = r;
    @(posedge clock);
    op_valid <= 1'b1;
    op_sel <= s;
    file_addr <= a;
    dest_sel <= dd;
    literal <= k;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    chk("acc", w, acc_r);
    chk("flags", {5'h00, c, dc, z}, {5'h00, cf, nf, zf});
    chk_bit("we", we, file_we_r);
    if (we)
    begin
      chk("wdata", r, file_wdata_r);
      chk("waddr", {1'b0, a}, {1'b0, file_waddr_r});
    end
    chk("dir_a", d[0], pa);
    chk("dir_b", d[1], pb);
    chk("dir_c", d[2], pc);
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial
  begin
    for (i = 0; i < 8'h80; i = i + 1)
      fm[i] = i[7:0];
    for (i = 0; i < 3; i = i + 1)
      d[i] = 8'hFF;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    op(3'h6, 7'h05, 1'b0, 8'h00);
    op(3'h4, 7'h00, 1'b1, 8'h3C);
    op(3'h1, 7'h05, 1'b1, 8'h00);
    op(3'h2, 7'h7F, 1'b0, 8'h00);
    op(3'h1, 7'h42, 1'b0, 8'h00);
    op(3'h2, 7'h05, 1'b1, 8'h00);
    op(3'h3, 7'h12, 1'b0, 8'h00);
    op(3'h3, 7'h05, 1'b1, 8'h00);
    op(3'h5, 7'h21, 1'b0, 8'h00);
    op(3'h5, 7'h05, 1'b1, 8'h00);
    op(3'h4, 7'h00, 1'b0, 8'hA5);
    for (i = 5; i < 9; i = i + 1)
      op(3'h6, i[6:0], 1'b0, 8'h00);
    op(3'h0, 7'h05, 1'b1, 8'h00);
    op(3'h7, 7'h05, 1'b1, 8'h00);
    // Mid-run reset: everything back to reset values, file contents kept
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    #1;
    chk("acc", 8'h00, acc_r);
    chk("flags", 8'h00, {5'h00, cf, nf, zf});
    chk_bit("we", 1'b0, file_we_r);
    chk("dir_a", 8'hFF, pa);
    chk("dir_b", 8'hFF, pb);
    chk("dir_c", 8'hFF, pc);
    @(posedge clock);
    nrst <= 1'b1;
    w = 8'h00;
    c = 1'b0;
    dc = 1'b0;
    z = 1'b0;
    for (i = 0; i < 3; i = i + 1)
      d[i] = 8'hFF;
    op(3'h2, 7'h7F, 1'b0, 8'h00);
    tally_and_finish;
  end
endmodule // byte_alu_sub_xor_swap_bench
